// ---- rtl/acg_top.sv ----
// low-speed bus clock gating and backup domain control behind an ahb-lite slave
//
// How it works
// - gate register at 0x1c resets to zero
// - bits 29..27 gate converter, power, backup clocks
// - bits 22, 21 gate second, first i2c
// - bits 18, 17 gate third, second serial
// - bit 14 second spi, bit 11 watchdog
// - bits 5, 4, 0 gate timers six, five, one
// - backup register at 0x20, 0x18, backup reset
// - backup register takes byte, half, word writes
// - protected fields ignore system reset
// - protected fields writable only when unlocked
// - bit 16 holds backup domain in reset
// - bit 15 enables rtc clock
// - bits 9:8 pick rtc clock source
// - bits 4:3 crystal drive, resets to 11
// - bit 1 reads one when crystal stable
// - bit 0 enables slow crystal
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns
module acg_top #(
   parameter int ADDR_W = 8
) (
   // clock and system reset
   input  wire logic                  CLK,
   input  wire logic                  RESET,
   // backup domain power reset and power unit unlock
   input  wire logic                  BKUP_POR,
   input  wire logic                  BACKUP_WRITE_UNLOCK,
   input  wire logic                  SLOW_XTAL_READY,
   // ahb-lite slave
   input  wire logic                  HSEL,
   input  wire logic [ADDR_W-1:0]     HADDR,
   input  wire logic [1:0]            HTRANS,
   input  wire logic                  HWRITE,
   input  wire logic [2:0]            HSIZE,
   input  wire logic [31:0]           HWDATA,
   input  wire logic                  HREADY,
   output logic      [31:0]           HRDATA,
   output logic                       HREADYOUT,
   output logic                       HRESP,
   // gated peripheral clocks, index order as acg_pkg::GATE_BITS
   output logic [acg_pkg::NUM_GATES-1:0] PERIPH_CLK,
   // backup domain controls
   output logic                       BKUP_DOMAIN_RESET,
   output logic                       RTC_CLOCK_GATE,
   output logic      [1:0]            RTC_SOURCE_SELECT,
   output logic      [1:0]            SLOW_CRYSTAL_DRIVE,
   output logic                       SLOW_CRYSTAL_BYPASS,
   output logic                       SLOW_CRYSTAL_ENABLE
);

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must lie between 6 and 32");
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [3:0] lane_mask(input logic [2:0] size, input logic [1:0] a);
      logic [3:0] m;
      m = 4'h0;
      case (size)
         acg_pkg::SIZE_BYTE: m = 4'h1 << a;
         acg_pkg::SIZE_HALF: m = a[1] ? 4'hc : 4'h3;
         acg_pkg::SIZE_WORD: m = 4'hf;
         default:            m = 4'h0;
      endcase
      return m;
   endfunction

   function automatic logic [31:0] lane_bits(input logic [3:0] m);
      return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
   endfunction

   // ------------------------------------------------------------
   // bus front end
   // ------------------------------------------------------------
   acg_pkg::acg_phase_t phase_ff;
   acg_pkg::acg_phase_t nxt_phase;
   logic [ADDR_W-1:0]   addr_ff;
   logic                write_ff;
   logic [3:0]          lanes_ff;
   logic                accept;
   logic                hit_gate;
   logic                hit_bkup;
   logic                wr_gate;
   logic                wr_bkup;
   logic [31:0]         gate_ff;
   logic [31:0]         bkup_value;
   logic                bkup_rst;
   logic [31:0]         rd_mux;

   // offsets widened or cut to the bus width once, so any legal ADDR_W decodes
   localparam logic [ADDR_W-1:0] GATE_ADDR = ADDR_W'(acg_pkg::GATE_OFFSET);
   localparam logic [ADDR_W-1:0] BKUP_ADDR = ADDR_W'(acg_pkg::BKUP_OFFSET);

   assign accept   = HSEL && HTRANS[1] && HREADY;
   assign hit_gate = addr_ff[ADDR_W-1:2] == GATE_ADDR[ADDR_W-1:2];
   assign hit_bkup = addr_ff[ADDR_W-1:2] == BKUP_ADDR[ADDR_W-1:2];
   // data phase is two cycles: write lands in the first, read sampled after it
   assign wr_gate  = (phase_ff == acg_pkg::PH_BUSY) && write_ff && hit_gate;
   assign wr_bkup  = (phase_ff == acg_pkg::PH_BUSY) && write_ff && hit_bkup;

   always_comb begin
      nxt_phase = phase_ff;
      case (phase_ff)
         acg_pkg::PH_IDLE: if (accept) nxt_phase = acg_pkg::PH_BUSY;
         acg_pkg::PH_BUSY: nxt_phase = acg_pkg::PH_IDLE;
         default:          nxt_phase = acg_pkg::PH_IDLE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         phase_ff <= acg_pkg::PH_IDLE;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         addr_ff  <= '0;
         write_ff <= 1'b0;
         lanes_ff <= 4'h0;
      end else if (phase_ff == acg_pkg::PH_IDLE && accept) begin
         addr_ff  <= HADDR;
         write_ff <= HWRITE;
         lanes_ff <= lane_mask(HSIZE, HADDR[1:0]);
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         HREADYOUT <= 1'b1;
      end else begin
         HREADYOUT <= !(phase_ff == acg_pkg::PH_IDLE && accept);
      end
   end

   // only okay answers exist; unmapped reads give zero, writes are dropped
   always_ff @(posedge CLK) begin
      if (RESET) begin
         HRESP <= 1'b0;
      end else begin
         HRESP <= 1'b0;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_gate) begin
         rd_mux = gate_ff;
      end else if (hit_bkup) begin
         rd_mux = bkup_value;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         HRDATA <= 32'h0000_0000;
      end else if (phase_ff == acg_pkg::PH_BUSY && !write_ff) begin
         HRDATA <= rd_mux;
      end
   end

   // ------------------------------------------------------------
   // clock gate register
   // ------------------------------------------------------------
   // reserved positions are never stored, so they read zero whatever is written
   always_ff @(posedge CLK) begin
      if (RESET) begin
         gate_ff <= acg_pkg::GATE_RESET;
      end else if (wr_gate) begin
         gate_ff <= ((gate_ff & ~lane_bits(lanes_ff)) | (HWDATA & lane_bits(lanes_ff)))
                    & acg_pkg::GATE_MASK;
      end
   end

   for (genvar g = 0; g < acg_pkg::NUM_GATES; g++) begin : g_gate
      acg_clk_gate u_gate (
         .clk_in  (CLK),
         .clk_out (PERIPH_CLK[g]),
         .enable  (gate_ff[acg_pkg::GATE_BITS[g]])
      );
   end

   // ------------------------------------------------------------
   // backup domain control register
   // ------------------------------------------------------------
   // lives off the system reset entirely; its own power reset loads 0x18, and the bit 16 soft reset resets every field but itself, drive to 11
   acg_backup_ctl u_bkup (
      .clk           (CLK),
      .bkup_por      (BKUP_POR),
      .wr_en         (wr_bkup),
      .lanes         (lanes_ff),
      .wdata         (HWDATA),
      .unlock        (BACKUP_WRITE_UNLOCK),
      .xtal_ready    (SLOW_XTAL_READY),
      .value         (bkup_value),
      .domain_rst_ff (bkup_rst)
   );

   assign BKUP_DOMAIN_RESET   = bkup_rst;
   assign RTC_CLOCK_GATE      = bkup_value[acg_pkg::B_RTC_EN];
   assign RTC_SOURCE_SELECT   = bkup_value[acg_pkg::B_SRC_HI:acg_pkg::B_SRC_LO];
   assign SLOW_CRYSTAL_DRIVE  = bkup_value[acg_pkg::B_DRV_HI:acg_pkg::B_DRV_LO];
   assign SLOW_CRYSTAL_BYPASS = bkup_value[acg_pkg::B_BYPASS];
   assign SLOW_CRYSTAL_ENABLE = bkup_value[acg_pkg::B_XTAL_EN];

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   chk_gate_reset: assert property (@(posedge CLK) RESET |=> gate_ff == 32'h0)
      else $error("gate register not zero after reset");

   chk_gate_high: assert property (@(posedge CLK) disable iff (RESET)
      wr_gate && lanes_ff[3] |=> gate_ff[29:27] == $past(HWDATA[29:27]))
      else $error("converter, power or backup gate missed a write");

   chk_gate_i2c: assert property (@(posedge CLK) disable iff (RESET)
      wr_gate && lanes_ff[2] |=> gate_ff[22:21] == $past(HWDATA[22:21]))
      else $error("i2c gate missed a write");

   chk_gate_serial: assert property (@(posedge CLK) disable iff (RESET)
      wr_gate && lanes_ff[2] |=> gate_ff[18:17] == $past(HWDATA[18:17]))
      else $error("serial gate missed a write");

   chk_gate_spi_wdog: assert property (@(posedge CLK) disable iff (RESET)
      wr_gate && lanes_ff[1] |=> {gate_ff[14], gate_ff[11]} ==
                                 {$past(HWDATA[14]), $past(HWDATA[11])})
      else $error("spi or watchdog gate missed a write");

   chk_gate_timers: assert property (@(posedge CLK) disable iff (RESET)
      wr_gate && lanes_ff[0] |=> {gate_ff[5:4], gate_ff[0]} ==
                                 {$past(HWDATA[5:4]), $past(HWDATA[0])})
      else $error("timer gate missed a write");

   chk_gate_reserved: assert property (@(posedge CLK) disable iff (RESET)
      (gate_ff & ~acg_pkg::GATE_MASK) == 32'h0)
      else $error("reserved gate bit set");

   chk_bkup_reset: assert property (@(posedge CLK)
      BKUP_POR |=> bkup_value == acg_pkg::BKUP_RESET_VAL)
      else $error("backup register wrong after backup reset");

   chk_bkup_lanes: assert property (@(posedge CLK) disable iff (BKUP_POR || bkup_rst)
      wr_bkup && !lanes_ff[1] |=> $stable(RTC_CLOCK_GATE))
      else $error("byte write disturbed another lane");

   chk_bkup_locked: assert property (@(posedge CLK) disable iff (BKUP_POR || bkup_rst)
      !BACKUP_WRITE_UNLOCK ##1 1'b1 |->
         $stable(RTC_SOURCE_SELECT) && $stable(SLOW_CRYSTAL_ENABLE))
      else $error("protected field changed while locked");

   chk_sys_reset_keeps: assert property (
      @(posedge CLK) disable iff (BKUP_POR || bkup_value[acg_pkg::B_SOFT_RST])
      RESET && !wr_bkup |=> $stable(RTC_SOURCE_SELECT) && $stable(RTC_CLOCK_GATE) &&
                            $stable(SLOW_CRYSTAL_ENABLE) && $stable(SLOW_CRYSTAL_BYPASS))
      else $error("system reset disturbed backup fields");

   chk_rtc_en_write: assert property (
      @(posedge CLK) disable iff (BKUP_POR || bkup_value[acg_pkg::B_SOFT_RST])
      wr_bkup && lanes_ff[1] && BACKUP_WRITE_UNLOCK |=>
         RTC_CLOCK_GATE == $past(HWDATA[acg_pkg::B_RTC_EN]))
      else $error("rtc clock enable missed a write");

   chk_rtc_src_write: assert property (
      @(posedge CLK) disable iff (BKUP_POR || bkup_value[acg_pkg::B_SOFT_RST])
      wr_bkup && lanes_ff[1] && BACKUP_WRITE_UNLOCK |=>
         RTC_SOURCE_SELECT == $past(HWDATA[acg_pkg::B_SRC_HI:acg_pkg::B_SRC_LO]))
      else $error("rtc source missed a write");

   chk_xtal_en_write: assert property (
      @(posedge CLK) disable iff (BKUP_POR || bkup_value[acg_pkg::B_SOFT_RST])
      wr_bkup && lanes_ff[0] && BACKUP_WRITE_UNLOCK |=>
         SLOW_CRYSTAL_ENABLE == $past(HWDATA[acg_pkg::B_XTAL_EN]))
      else $error("crystal enable missed a write");

   chk_drive_reset: assert property (
      @(posedge CLK) bkup_rst |-> SLOW_CRYSTAL_DRIVE == acg_pkg::DRIVE_RESET)
      else $error("drive level not restored by backup reset");

   chk_resp_okay: assert property (@(posedge CLK) disable iff (RESET) !HRESP)
      else $error("error response driven");

   chk_soft_reset: assert property (@(posedge CLK) disable iff (BKUP_POR)
      bkup_value[acg_pkg::B_SOFT_RST] |=> BKUP_DOMAIN_RESET ##1 !SLOW_CRYSTAL_ENABLE)
      else $error("soft reset did not hold the backup domain");

   chk_stable_needs_en: assert property (@(posedge CLK)
      bkup_value[acg_pkg::B_STABLE] |->
         $past(SLOW_CRYSTAL_ENABLE) && $past(SLOW_XTAL_READY))
      else $error("stable flag without running crystal");

   chk_ready_wait: assert property (@(posedge CLK) disable iff (RESET)
      accept && HREADYOUT |=> !HREADYOUT ##1 HREADYOUT)
      else $error("data phase not exactly one wait cycle");

   cov_gate_write: cover property (@(posedge CLK) wr_gate && lanes_ff == 4'hf);
   cov_bkup_byte: cover property (@(posedge CLK) wr_bkup && lanes_ff == 4'h4);
   cov_soft_reset: cover property (@(posedge CLK) bkup_rst && !BKUP_POR);
   cov_locked_write: cover property (@(posedge CLK) wr_bkup && !BACKUP_WRITE_UNLOCK);
   cov_stable: cover property (@(posedge CLK) bkup_value[acg_pkg::B_STABLE]);

endmodule

// ---- rtl/acg_pkg.sv ----
// shared constants for the low-speed bus clock gates and backup domain control
package acg_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0]  GATE_OFFSET    = 8'h1c;
   localparam logic [7:0]  BKUP_OFFSET    = 8'h20;
   localparam logic [31:0] GATE_RESET     = 32'h0000_0000;
   localparam logic [31:0] BKUP_RESET_VAL = 32'h0000_0018;

   // ------------------------------------------------------------
   // clock gate register fields
   // ------------------------------------------------------------
   localparam int          NUM_GATES  = 12;
   localparam logic [31:0] GATE_MASK  = 32'h3866_4831;
   localparam int          B_CONV     = 29;
   localparam int          B_PWR      = 28;
   localparam int          B_BKIF     = 27;
   localparam int          B_I2C2     = 22;
   localparam int          B_I2C1     = 21;
   localparam int          B_SER3     = 18;
   localparam int          B_SER2     = 17;
   localparam int          B_SPI2     = 14;
   localparam int          B_WDOG     = 11;
   localparam int          B_TIM6     = 5;
   localparam int          B_TIM5     = 4;
   localparam int          B_TIM1     = 0;
   // gated clock output index n is driven by gate bit GATE_BITS[n]
   localparam int GATE_BITS [NUM_GATES] = '{B_TIM1, B_TIM5, B_TIM6, B_WDOG, B_SPI2, B_SER2,
                                            B_SER3, B_I2C1, B_I2C2, B_BKIF, B_PWR, B_CONV};

   // ------------------------------------------------------------
   // backup domain control fields
   // ------------------------------------------------------------
   localparam int          B_SOFT_RST = 16;
   localparam int          B_RTC_EN   = 15;
   localparam int          B_SRC_HI   = 9;
   localparam int          B_SRC_LO   = 8;
   localparam int          B_DRV_HI   = 4;
   localparam int          B_DRV_LO   = 3;
   localparam int          B_BYPASS   = 2;
   localparam int          B_STABLE   = 1;
   localparam int          B_XTAL_EN  = 0;
   localparam logic [1:0]  DRIVE_RESET = 2'h3;

   // rtc source encodings
   localparam logic [1:0]  SRC_NONE   = 2'h0;
   localparam logic [1:0]  SRC_SLOW   = 2'h1;
   localparam logic [1:0]  SRC_INT40K = 2'h2;
   localparam logic [1:0]  SRC_FAST   = 2'h3;

   // ------------------------------------------------------------
   // bus encodings
   // ------------------------------------------------------------
   localparam logic [2:0]  SIZE_BYTE  = 3'h0;
   localparam logic [2:0]  SIZE_HALF  = 3'h1;
   localparam logic [2:0]  SIZE_WORD  = 3'h2;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b01,
      PH_BUSY = 2'b10
   } acg_phase_t;

endpackage

// ---- rtl/acg_clk_gate.sv ----
// latch-based glitch-free clock gating cell
`timescale 1ns/1ns
module acg_clk_gate (
   // clocks
   input  wire logic clk_in,
   output wire logic clk_out,
   // control
   input  wire logic enable
);

   logic en_lat;

   // enable only moves while the clock is low, so no runt pulse escapes
   always_latch begin
      if (!clk_in) begin
         en_lat <= enable;
      end
   end

   assign clk_out = clk_in & en_lat;

endmodule

// ---- rtl/acg_backup_ctl.sv ----
// backup domain control register with its own reset and write protection
`timescale 1ns/1ns
module acg_backup_ctl (
   // clock and backup domain power reset
   input  wire logic        clk,
   input  wire logic        bkup_por,
   // register write
   input  wire logic        wr_en,
   input  wire logic [3:0]  lanes,
   input  wire logic [31:0] wdata,
   input  wire logic        unlock,
   // crystal status
   input  wire logic        xtal_ready,
   // register state
   output logic      [31:0] value,
   output logic             domain_rst_ff
);

   logic       soft_rst_ff;
   logic       rtc_en_ff;
   logic [1:0] src_ff;
   logic [1:0] drive_ff;
   logic       bypass_ff;
   logic       xtal_en_ff;
   logic       stable_ff;
   logic       dom_rst;
   logic       prot_wr;

   // soft reset bit only yields to the power reset, else it could never release
   assign dom_rst = bkup_por | soft_rst_ff;
   assign prot_wr = wr_en & unlock;

   always_ff @(posedge clk) begin
      if (bkup_por) begin
         soft_rst_ff <= 1'b0;
      end else if (wr_en && lanes[2]) begin
         soft_rst_ff <= wdata[acg_pkg::B_SOFT_RST];
      end
   end

   // untouched by the system reset: only the backup domain reset clears these
   always_ff @(posedge clk) begin
      if (dom_rst) begin
         rtc_en_ff  <= 1'b0;
         src_ff     <= acg_pkg::SRC_NONE;
         bypass_ff  <= 1'b0;
         xtal_en_ff <= 1'b0;
      end else if (prot_wr) begin
         if (lanes[1]) begin
            rtc_en_ff <= wdata[acg_pkg::B_RTC_EN];
            src_ff    <= wdata[acg_pkg::B_SRC_HI:acg_pkg::B_SRC_LO];
         end
         if (lanes[0]) begin
            bypass_ff  <= wdata[acg_pkg::B_BYPASS];
            xtal_en_ff <= wdata[acg_pkg::B_XTAL_EN];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (dom_rst) begin
         drive_ff <= acg_pkg::DRIVE_RESET;
      end else if (wr_en && lanes[0]) begin
         drive_ff <= wdata[acg_pkg::B_DRV_HI:acg_pkg::B_DRV_LO];
      end
   end

   always_ff @(posedge clk) begin
      if (dom_rst) begin
         stable_ff <= 1'b0;
      end else begin
         stable_ff <= xtal_en_ff & xtal_ready;
      end
   end

   always_ff @(posedge clk) begin
      domain_rst_ff <= dom_rst;
   end

   always_comb begin
      value                                        = 32'h0000_0000;
      value[acg_pkg::B_SOFT_RST]                   = soft_rst_ff;
      value[acg_pkg::B_RTC_EN]                     = rtc_en_ff;
      value[acg_pkg::B_SRC_HI:acg_pkg::B_SRC_LO]   = src_ff;
      value[acg_pkg::B_DRV_HI:acg_pkg::B_DRV_LO]   = drive_ff;
      value[acg_pkg::B_BYPASS]                     = bypass_ff;
      value[acg_pkg::B_STABLE]                     = stable_ff;
      value[acg_pkg::B_XTAL_EN]                    = xtal_en_ff;
   end

endmodule

// ---- dv/acg_top_test.sv ----
// self-checking bench for the peripheral clock gates and backup domain control
`timescale 1ns/1ns
module acg_top_test;
   // ---------------------------------------------------------------
   // design ports and bench state
   // ---------------------------------------------------------------
   logic                          CLK, RESET, BKUP_POR, BACKUP_WRITE_UNLOCK, SLOW_XTAL_READY;
   logic                          HSEL, HWRITE, HREADYOUT, HRESP, BKUP_DOMAIN_RESET;
   logic [7:0]                    HADDR;
   logic [1:0]                    HTRANS, RTC_SOURCE_SELECT, SLOW_CRYSTAL_DRIVE;
   logic [2:0]                    HSIZE;
   logic [31:0]                   HWDATA, HRDATA;
   logic [acg_pkg::NUM_GATES-1:0] PERIPH_CLK;
   logic                          RTC_CLOCK_GATE, SLOW_CRYSTAL_BYPASS, SLOW_CRYSTAL_ENABLE;
   logic [31:0]                   exp_q[$];
   logic [31:0]                   gt, bk, r, mon_exp;
   logic                          dph_rd;
   int                            err_count, total_checks;

   acg_top #(.ADDR_W(8)) acg_top_i (
      .CLK(CLK), .RESET(RESET), .BKUP_POR(BKUP_POR),
      .BACKUP_WRITE_UNLOCK(BACKUP_WRITE_UNLOCK), .SLOW_XTAL_READY(SLOW_XTAL_READY),
      .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
      .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
      .HRESP(HRESP), .PERIPH_CLK(PERIPH_CLK), .BKUP_DOMAIN_RESET(BKUP_DOMAIN_RESET),
      .RTC_CLOCK_GATE(RTC_CLOCK_GATE), .RTC_SOURCE_SELECT(RTC_SOURCE_SELECT),
      .SLOW_CRYSTAL_DRIVE(SLOW_CRYSTAL_DRIVE), .SLOW_CRYSTAL_BYPASS(SLOW_CRYSTAL_BYPASS),
      .SLOW_CRYSTAL_ENABLE(SLOW_CRYSTAL_ENABLE)
   );

   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end

   // ---------------------------------------------------------------
   // compare, report and bus tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // bounded: a slave that never answers ends the run
   task automatic wait_ready();
      int k;
      for (k = 0; k < 16; k++) begin
         @(posedge CLK);
         if (HREADYOUT === 1'b1) break;
      end
      if (k == 16) begin
         err_count++;
         $display("FAIL hreadyout expected 1 seen timeout");
         wrap_up();
      end
   endtask

   // entered just after a rising edge; returns at the edge ending the data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [2:0] sz,
                      input logic [31:0] d);
      HSEL   <= 1'b1;
      HTRANS <= 2'h2;
      HADDR  <= a;
      HWRITE <= w;
      HSIZE  <= sz;
      wait_ready();
      HSEL   <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      wait_ready();
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, acg_pkg::SIZE_WORD, 32'h0);
   endtask

   function automatic logic [11:0] gexp(input logic [31:0] g);
      logic [11:0] v;
      for (int n = 0; n < acg_pkg::NUM_GATES; n++) v[n] = g[acg_pkg::GATE_BITS[n]];
      return v;
   endfunction

   // look at the gated clocks mid high phase and mid low phase
   task automatic clk_chk(input logic [11:0] e);
      @(posedge CLK);
      #2;
      check("periph_clk_high", {20'h0, PERIPH_CLK}, {20'h0, e});
      #5;
      check("periph_clk_low", {20'h0, PERIPH_CLK}, 32'h0);
      @(posedge CLK);
   endtask

   task automatic gw(input logic [31:0] d);
      gt = d;
      bus(1'b1, acg_pkg::GATE_OFFSET, acg_pkg::SIZE_WORD, d);
      rd(acg_pkg::GATE_OFFSET, gt);
      clk_chk(gexp(gt));
   endtask

   task automatic bw(input logic [7:0] a, input logic [2:0] sz, input logic [31:0] d);
      logic [31:0] m;
      m = (sz == acg_pkg::SIZE_BYTE) ? (32'hff << (8 * a[1:0])) :
          (sz == acg_pkg::SIZE_HALF) ? (a[1] ? 32'hffff_0000 : 32'h0000_ffff) : 32'hffff_ffff;
      m = m & (BACKUP_WRITE_UNLOCK ? 32'h0001_831d : 32'h0001_0018);
      bk = (bk & ~m) | (d & m);
      if (bk[16]) bk = 32'h0001_0018;
      bus(1'b1, a, sz, d);
   endtask

   task automatic bchk();
      rd(acg_pkg::BKUP_OFFSET, bk | {30'h0, bk[0] & SLOW_XTAL_READY, 1'b0});
      check("backup_outputs", {16'h0, RTC_CLOCK_GATE, 5'h0, RTC_SOURCE_SELECT, 3'h0,
            SLOW_CRYSTAL_DRIVE, SLOW_CRYSTAL_BYPASS, 1'b0, SLOW_CRYSTAL_ENABLE},
            bk & 32'h0000_831d);
      check("domain_reset", {31'h0, BKUP_DOMAIN_RESET}, {31'h0, bk[16]});
   endtask

   // ---------------------------------------------------------------
   // read monitor: compares each completed read with the oldest note
   // ---------------------------------------------------------------
   always @(posedge CLK) begin
      if (dph_rd && HREADYOUT === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("read_note", 32'h1, 32'h0);
         end else begin
            mon_exp = exp_q.pop_front();
            check("hrdata", HRDATA, mon_exp);
            check("hresp", {31'h0, HRESP}, 32'h0);
         end
      end
      if (HREADYOUT === 1'b1) dph_rd = HSEL && HTRANS[1] && !HWRITE;
      if (RESET) dph_rd = 1'b0;
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      RESET = 1'b1;
      BKUP_POR = 1'b1;
      BACKUP_WRITE_UNLOCK = 1'b0;
      SLOW_XTAL_READY = 1'b0;
      HSEL = 1'b0;
      HADDR = 8'h0;
      HTRANS = 2'h0;
      HWRITE = 1'b0;
      HSIZE = 3'h0;
      HWDATA = 32'h0;
      err_count = 0;
      total_checks = 0;
      dph_rd = 1'b0;
      gt = 32'h0;
      bk = 32'h0000_0018;
      repeat (4) @(posedge CLK);
      RESET <= 1'b0;
      BKUP_POR <= 1'b0;
      @(posedge CLK);
      void'($urandom(32'h2526271d));
      rd(acg_pkg::GATE_OFFSET, 32'h0);
      bchk();
      clk_chk(12'h0);
      for (int n = 0; n < acg_pkg::NUM_GATES; n++) gw(32'h1 << acg_pkg::GATE_BITS[n]);
      // reserved positions always written as zero
      repeat (4) begin
         r = $urandom() & acg_pkg::GATE_MASK;
         gw(r);
      end
      bus(1'b1, 8'h24, acg_pkg::SIZE_WORD, 32'hffff_ffff);
      rd(8'h24, 32'h0);
      rd(acg_pkg::GATE_OFFSET, gt);
      BACKUP_WRITE_UNLOCK <= 1'b1;
      @(posedge CLK);
      // every source code and drive level, bypass kept set
      for (int i = 0; i < 4; i++) begin
         bw(acg_pkg::BKUP_OFFSET, acg_pkg::SIZE_WORD,
            {16'h0, i[0], 5'h0, i[1:0], 3'h0, ~i[1:0], 3'b101});
         bchk();
      end
      SLOW_XTAL_READY <= 1'b1;
      repeat (2) @(posedge CLK);
      bchk();
      SLOW_XTAL_READY <= 1'b0;
      repeat (2) @(posedge CLK);
      bchk();
      BACKUP_WRITE_UNLOCK <= 1'b0;
      @(posedge CLK);
      bw(acg_pkg::BKUP_OFFSET, acg_pkg::SIZE_WORD, 32'h0000_0018);
      bchk();
      BACKUP_WRITE_UNLOCK <= 1'b1;
      @(posedge CLK);
      bw(acg_pkg::BKUP_OFFSET, acg_pkg::SIZE_BYTE, 32'h0000_0004);
      bchk();
      bw(acg_pkg::BKUP_OFFSET + 8'h1, acg_pkg::SIZE_BYTE, 32'h0000_0200);
      bchk();
      bw(acg_pkg::BKUP_OFFSET, acg_pkg::SIZE_HALF, 32'h0000_8115);
      bchk();
      RESET <= 1'b1;
      repeat (2) @(posedge CLK);
      RESET <= 1'b0;
      @(posedge CLK);
      gt = 32'h0;
      rd(acg_pkg::GATE_OFFSET, gt);
      clk_chk(12'h0);
      bchk();
      bw(acg_pkg::BKUP_OFFSET + 8'h2, acg_pkg::SIZE_BYTE, 32'h0001_0000);
      bchk();
      bw(acg_pkg::BKUP_OFFSET + 8'h2, acg_pkg::SIZE_BYTE, 32'h0000_0000);
      bchk();
      bw(acg_pkg::BKUP_OFFSET, acg_pkg::SIZE_WORD, 32'h0000_8307);
      bchk();
      BKUP_POR <= 1'b1;
      @(posedge CLK);
      BKUP_POR <= 1'b0;
      bk = 32'h0000_0018;
      @(posedge CLK);
      bchk();
      repeat (2) @(posedge CLK);
      check("notes_left", exp_q.size(), 32'h0);
      wrap_up();
   end
endmodule
